/* bench/feature_soft_disable_control_bench.sv */
// self-checking bench for the feature soft-disable control block
`timescale 1ns/1ps
`default_nettype none
module feature_soft_disable_control_bench;
  import feature_ctl_pkg::*;
  logic        i_clk, i_rstn, i_hsel, i_hwrite, hready, o_hresp, pri, wr_seen;
  logic [7:0]  i_haddr, dis;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata, o_hrdata, rd, rnd;
  feat_en_type o_feat_en;
  int          n_errors, check_count;

  feature_soft_disable_control dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(hready),
    .o_hrdata(o_hrdata), .o_hreadyout(hready), .o_hresp(o_hresp), .o_feat_en(o_feat_en));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ---------------------------------
  // model and helpers
  // ---------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // exclusive pair: last newly enabled one wins
  function automatic logic [7:0] en_of(input logic [7:0] d, input logic p);
    logic u, m;
    u = ~d[UTOPIA_BIT] & (d[MAC_A_BIT] | p);
    m = ~d[MAC_A_BIT] & (d[UTOPIA_BIT] | ~p);
    return {~d[PCI_BIT], ~d[HSS_BIT], u, m, ~d[MAC_C_BIT], ~d[USB0_BIT], ~d[USB1_BIT], ~d[ECC_BIT]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= HTRANS_NONSEQ;
    i_haddr <= a;
    i_hwrite <= w;
    i_hsize <= sz;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    rd = o_hrdata;
    chk("hresp", 32'(o_hresp), 32'h0);
  endtask

  task automatic ck_all;
    #1 chk("enables", 32'(o_feat_en), 32'(en_of(dis, pri)));
    xfer(1'b0, FEAT_DISABLE_OFS, 32'h0, HSIZE_WORD);
    chk("disable reg", rd, {24'h0, dis});
    xfer(1'b0, FEAT_STATUS_OFS, 32'h0, HSIZE_WORD);
    chk("status", rd, {23'h0, wr_seen, en_of(dis, pri)});
  endtask

  task automatic wr(input logic [7:0] v);
    rnd = xs(rnd);
    if (dis[2] & dis[3] & ~v[2] & ~v[3]) v[3] = 1'b1;
    if (dis[2] & ~v[2]) pri = 1'b1;
    if (dis[3] & ~v[3]) pri = 1'b0;
    dis = v;
    wr_seen = 1'b1;
    xfer(1'b1, FEAT_DISABLE_OFS, {rnd[31:8], v}, HSIZE_WORD);
    repeat (2) @(posedge i_clk);
    ck_all();
  endtask

  task automatic do_reset;
    i_rstn <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    dis = FEAT_DISABLE_RST;
    pri = 1'b0;
    wr_seen = 1'b0;
  endtask

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial
  begin
    i_rstn = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 8'h00;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h0;
    i_hwdata = 32'h0;
    rnd = 32'h0000_0012;
    do_reset();
    ck_all();
    for (int i = 0; i < 8; i++) wr(8'h01 << i);
    // exclusive pair handover both ways
    wr(8'h0C);
    wr(8'h04);
    wr(8'h00);
    wr(8'h08);
    wr(8'h00);
    for (int i = 0; i < 20; i++)
    begin
      rnd = xs(rnd);
      wr(rnd[7:0]);
    end
    // refused writes leave everything in place
    for (int i = 0; i < 3; i++) xfer(1'b1, FEAT_DISABLE_OFS, 32'hFF, (i == 2) ? 3'h3 : 3'(i));
    xfer(1'b1, FEAT_STATUS_OFS, 32'hFF, HSIZE_WORD);
    xfer(1'b1, 8'h08, 32'hFF, HSIZE_WORD);
    xfer(1'b0, 8'h08, 32'h0, HSIZE_WORD);
    chk("unmapped", rd, 32'h0);
    xfer(1'b0, FEAT_DISABLE_OFS, 32'h0, 3'h0);
    chk("byte read", rd, 32'h0);
    repeat (2) @(posedge i_clk);
    ck_all();
    do_reset();
    ck_all();
    wr(8'hFF);
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    give_verdict();
  end
endmodule // feature_soft_disable_control_bench
`default_nettype wire

/* rtl/feature_ctl_pkg.sv */
// constants and types for the feature soft-disable control block
package feature_ctl_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] FEAT_DISABLE_OFS = 8'h00;
  localparam logic [7:0] FEAT_STATUS_OFS  = 8'h04;

  // field positions in feature_disable_register (1 = disabled)
  localparam int PCI_BIT    = 0;
  localparam int HSS_BIT    = 1;
  localparam int UTOPIA_BIT = 2;
  localparam int MAC_A_BIT  = 3;
  localparam int MAC_C_BIT  = 4;
  localparam int USB0_BIT   = 5;
  localparam int USB1_BIT   = 6;
  localparam int ECC_BIT    = 7;
  localparam int NFEAT      = 8;

  // reset value: all enabled except UTOPIA (engine A MACs win)
  localparam logic [7:0] FEAT_DISABLE_RST = 8'h04;

  // enables after reset, struct order, as resolved from FEAT_DISABLE_RST
  localparam logic [7:0] FEAT_EN_RST      = 8'hDF;

  // status register bit 8: written since reset
  localparam int WRITTEN_BIT = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic pci;
    logic hss_pair;
    logic utopia;
    logic mac_a;
    logic mac_c;
    logic usb0;
    logic usb1;
    logic ecc;
  } feat_en_type;

endpackage

/* rtl/feature_resolve.sv */
// resolves the written disable bits into legal per-unit enables
`timescale 1ns/1ps
`default_nettype none
module feature_resolve
  import feature_ctl_pkg::*;
(
  // raw disable bits and priority of last exclusive write
  input  wire logic [7:0]  i_dis,
  input  wire logic        i_utopia_pri,
  // legal enables
  output feat_en_type      o_en
);
  always_comb
  begin
    o_en.pci      = ~i_dis[PCI_BIT];
    o_en.hss_pair = ~i_dis[HSS_BIT];
    o_en.mac_c    = ~i_dis[MAC_C_BIT];
    o_en.usb0     = ~i_dis[USB0_BIT];
    o_en.usb1     = ~i_dis[USB1_BIT];
    o_en.ecc      = ~i_dis[ECC_BIT];
    // both requested: the later-enabled one wins
    o_en.utopia   = ~i_dis[UTOPIA_BIT] & (i_dis[MAC_A_BIT] | i_utopia_pri);
    o_en.mac_a    = ~i_dis[MAC_A_BIT] & ~o_en.utopia;
  end
endmodule // feature_resolve
`default_nettype wire

/* rtl/feature_soft_disable_control.sv */
// AHB-Lite register bank for feature soft-disable with per-unit enables
`timescale 1ns/1ps
`default_nettype none
module feature_soft_disable_control
  import feature_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // per-unit enables, low isolates the unit
  output feature_ctl_pkg::feat_en_type o_feat_en
);
  import feature_ctl_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit_disable(input logic [7:0] a);
    return a == FEAT_DISABLE_OFS;
  endfunction

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic       wr_pend_ff, nxt_wr_pend;
  logic       rd_pend_ff, nxt_rd_pend;
  logic [7:0] addr_ff,    nxt_addr;
  logic       sel_ok;

  assign sel_ok = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ) & (i_hsize == HSIZE_WORD);

  always_comb
  begin
    nxt_wr_pend = sel_ok & i_hwrite;
    nxt_rd_pend = sel_ok & ~i_hwrite;
    nxt_addr    = sel_ok ? i_haddr : addr_ff;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff    <= nxt_addr;
    end
  end

  // ----------------------------------------
  // feature_disable_register
  // ----------------------------------------
  logic [7:0]  dis_ff,     nxt_dis;
  logic        upri_ff,    nxt_upri;
  logic        written_ff, nxt_written;
  feat_en_type en_comb;
  feat_en_type en_ff;
  logic        dis_wr;

  assign dis_wr = wr_pend_ff & hit_disable(addr_ff);

  always_comb
  begin
    nxt_dis     = dis_ff;
    nxt_upri    = upri_ff;
    nxt_written = written_ff;
    if (dis_wr)
    begin
      nxt_dis     = i_hwdata[7:0];
      nxt_written = 1'b1;
      // exclusive pair: whichever turns on afresh takes priority, UTOPIA if both do in one write
      if (!i_hwdata[UTOPIA_BIT] && dis_ff[UTOPIA_BIT])
        nxt_upri = 1'b1;
      else if (!i_hwdata[MAC_A_BIT] && dis_ff[MAC_A_BIT])
        nxt_upri = 1'b0;
    end
  end

  feature_resolve u_resolve (
    .i_dis        (dis_ff),
    .i_utopia_pri (upri_ff),
    .o_en         (en_comb)
  );

  // held until rewritten or reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      dis_ff     <= FEAT_DISABLE_RST;
      upri_ff    <= 1'b0;
      written_ff <= 1'b0;
      en_ff      <= feat_en_type'(FEAT_EN_RST);
    end
    else
    begin
      dis_ff     <= nxt_dis;
      upri_ff    <= nxt_upri;
      written_ff <= nxt_written;
      en_ff      <= en_comb;
    end
  end

  assign o_feat_en = en_ff;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (sel_ok && !i_hwrite)
    begin
      case (i_haddr)
        FEAT_DISABLE_OFS: nxt_rdata = {24'h00_0000, nxt_dis};
        FEAT_STATUS_OFS:  nxt_rdata = {23'h00_0000, nxt_written, en_comb};
        default:          nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_hrdata    = rdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence disable_write_s;
    dis_wr;
  endsequence

  // write that newly enables utopia
  sequence utopia_fresh_s;
    dis_wr && !i_hwdata[UTOPIA_BIT] && dis_ff[UTOPIA_BIT];
  endsequence

  // write that newly enables engine A macs only
  sequence mac_a_fresh_s;
    dis_wr && !i_hwdata[MAC_A_BIT] && dis_ff[MAC_A_BIT] &&
    (i_hwdata[UTOPIA_BIT] || !dis_ff[UTOPIA_BIT]);
  endsequence

  sequence disable_read_s;
    sel_ok && !i_hwrite && hit_disable(i_haddr);
  endsequence

  write_takes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    disable_write_s |=> dis_ff == $past(i_hwdata[7:0]))
    else $error("disable register not loaded");

  read_back_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    disable_read_s |=> o_hrdata == {24'h00_0000, dis_ff})
    else $error("disable register read back wrong");

  isolate_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    disable_write_s ##1 1'b1 |=> o_feat_en.usb0 == ~$past(dis_ff[USB0_BIT], 1))
    else $error("usb0 enable not following register");

  pci_whole_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.pci == ~$past(dis_ff[PCI_BIT]))
    else $error("pci enable wrong");

  hss_pair_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.hss_pair == ~$past(dis_ff[HSS_BIT]))
    else $error("serial pair enable wrong");

  excl_pair_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(o_feat_en.utopia && o_feat_en.mac_a))
    else $error("utopia and engine A macs both on");

  utopia_only_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !dis_ff[UTOPIA_BIT] && dis_ff[MAC_A_BIT] |=> o_feat_en.utopia && !o_feat_en.mac_a)
    else $error("utopia alone not enabled");

  mac_a_only_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !dis_ff[MAC_A_BIT] && dis_ff[UTOPIA_BIT] |=> o_feat_en.mac_a && !o_feat_en.utopia)
    else $error("engine A macs alone not enabled");

  utopia_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    utopia_fresh_s |-> ##2 (o_feat_en.utopia && !o_feat_en.mac_a))
    else $error("newly enabled utopia did not win");

  mac_a_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mac_a_fresh_s |-> ##2 (o_feat_en.mac_a && !o_feat_en.utopia))
    else $error("newly enabled engine A macs did not win");

  mac_c_sep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.mac_c == ~$past(dis_ff[MAC_C_BIT]))
    else $error("engine C mac enable wrong");

  usb0_sep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.usb0 == ~$past(dis_ff[USB0_BIT]))
    else $error("usb0 enable wrong");

  usb1_sep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.usb1 == ~$past(dis_ff[USB1_BIT]))
    else $error("usb1 enable wrong");

  ecc_sep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_feat_en.ecc == ~$past(dis_ff[ECC_BIT]))
    else $error("ecc enable wrong");

  hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !dis_wr |=> $stable(dis_ff))
    else $error("disable register changed without write");

  en_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $stable(dis_ff) && $stable(upri_ff) |=> $stable(o_feat_en))
    else $error("enables changed without register change");

endmodule // feature_soft_disable_control
`default_nettype wire
